// *** verilog/rcid_consts.vh ***
// constants for the refresh configuration and identification register bank
`ifndef RCID_CONSTS_VH
`define RCID_CONSTS_VH

// ---------------------------------------------------------------
// register select codes on address bits 19:18 with the select pin
// ---------------------------------------------------------------
`define RCID_SEL_REFRESH   2'h0
`define RCID_SEL_IDENT     2'h1
`define RCID_SEL_NONE      2'h3

// ---------------------------------------------------------------
// software access sequence
// ---------------------------------------------------------------
`define RCID_SW_REFRESH    16'h0000
`define RCID_SW_IDENT      16'h0002
`define RCID_SW_ADDR       23'h7f_ffff

// ---------------------------------------------------------------
// refresh_control field positions and reset value
// ---------------------------------------------------------------
`define RCID_PAR_LSB       0
`define RCID_PAR_MSB       2
`define RCID_DS_BIT        4
`define RCID_PAGE_BIT      7
`define RCID_PAR_NONE      3'h4
`define RCID_REFRESH_RESET 16'h0010
`define RCID_REFRESH_MASK  16'h0097

// ---------------------------------------------------------------
// identification_word fields
// ---------------------------------------------------------------
`define RCID_ID_ROW_256    1'b1
`define RCID_ID_DENSITY    3'h3
`define RCID_ID_GENERATION 3'h2

// ---------------------------------------------------------------
// timing, in nanoseconds
// ---------------------------------------------------------------
`define RCID_CLK_PERIOD_NS 50
`define RCID_DPD_EXIT_NS   10000
`define RCID_INIT_NS       150000

`endif

// *** verilog/rcid_sync.v ***
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module rcid_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // pins and synchronised result
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_sync
);

  reg [WIDTH-1:0] st1_reg;
  reg [WIDTH-1:0] st2_reg;
  reg [WIDTH-1:0] st3_reg;
  reg [WIDTH-1:0] out_reg;
  genvar          i;

  // first stage feeds only the second
  always @(posedge ref_clk) begin
    if (rst) begin
      st1_reg <= {WIDTH{1'b0}};
      st2_reg <= {WIDTH{1'b0}};
      st3_reg <= {WIDTH{1'b0}};
    end else begin
      st1_reg <= pin_in;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  // per bit: a change counts only once two stages agree, filtering a one-cycle glitch
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge ref_clk) begin
        if (rst) begin
          out_reg[i] <= 1'b0;
        end else if (st2_reg[i] == st3_reg[i]) begin
          out_reg[i] <= st3_reg[i];
        end
      end
    end
  endgenerate

  assign pin_sync = out_reg;

endmodule

// *** verilog/rcid_timer.v ***
// run-length timer: done once run has stayed high for COUNT cycles
`timescale 1ns/1ps
module rcid_timer #(
  parameter COUNT = 200,
  parameter W     = 12
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rst,
  // control and result
  input  wire run,
  output wire done
);

  localparam [31:0]  LAST_WIDE = COUNT - 1;
  localparam [W-1:0] LAST      = LAST_WIDE[W-1:0];

  reg [W-1:0] cnt_reg;

  // restarts whenever run drops, so only an unbroken interval counts
  always @(posedge ref_clk) begin
    if (rst || !run) begin
      cnt_reg <= {W{1'b0}};
    end else if (cnt_reg != LAST) begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = run && (cnt_reg == LAST);

endmodule

// *** verilog/rcid_regs.v ***
// refresh configuration and identification registers with deep power-down control
//
// Behaviour
// RULE1: partial refresh code selects full, bottom half/quarter/eighth, none, or top half/quarter/eighth.
// RULE2: while deep power-down is active all refresh stops and array contents count as lost.
// RULE3: on leaving deep power-down a 150 us initialization runs before normal access resumes.
// RULE4: deep power-down starts when the deep-sleep bit is zero and chip select then goes high.
// RULE5: chip select held low for 10 us ends deep power-down and sets the deep-sleep bit again.
// RULE6: register contents are kept through deep power-down.
// RULE7: bit 7 of refresh_control enables asynchronous page mode and resets to zero.
// RULE8: identification_word is read-only and writes leave it unchanged.
// RULE9: identification_word is chosen by select pin with address 19:18 = 01 or sequence data 0002h.
// RULE10: identification_word holds row length, revision, density, generation and vendor fields.
// RULE11: a lower-half die responds only while its virtual select input is low.
// RULE12: an upper-half die responds only while its virtual select input is high.
// RULE13: refresh_control is chosen by select pin with address 19:18 = 00 or sequence data 0000h.
`timescale 1ns/1ps
`include "rcid_consts.vh"
module rcid_regs #(
  parameter       UPPER_DIE = 0,
  parameter [3:0] REVISION  = 4'h5,    // arbitrary value
  parameter [4:0] VENDOR    = 5'h15    // arbitrary value
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // memory bus pins
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        register_select_pin,
  input  wire        virtual_select_input,
  input  wire [22:0] addr,
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  // refresh and power state
  output reg         refresh_run,
  output reg  [22:0] refresh_lo_addr,
  output reg  [22:0] refresh_hi_addr,
  output reg         page_mode_en,
  output reg         deep_sleep_active,
  output reg         init_busy,
  output reg         contents_lost,
  output reg         die_selected
);

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // both are least times, so round up
  localparam EXIT_CYC = (`RCID_DPD_EXIT_NS + `RCID_CLK_PERIOD_NS - 1) / `RCID_CLK_PERIOD_NS;
  localparam INIT_CYC = (`RCID_INIT_NS + `RCID_CLK_PERIOD_NS - 1) / `RCID_CLK_PERIOD_NS;

  // software sequence states, one-hot
  localparam [3:0] SW_IDLE = 4'h1;
  localparam [3:0] SW_ONE  = 4'h2;
  localparam [3:0] SW_TWO  = 4'h4;
  localparam [3:0] SW_SEL  = 4'h8;

  localparam [0:0] UPPER = (UPPER_DIE != 0);

  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  // refresh region bound for a partial refresh code
  function [22:0] par_bound;
    input [2:0] code;
    input       hi;
    begin
      case (code)
        3'h0:    par_bound = hi ? 23'h7f_ffff : 23'h00_0000;
        3'h1:    par_bound = hi ? 23'h3f_ffff : 23'h00_0000;
        3'h2:    par_bound = hi ? 23'h1f_ffff : 23'h00_0000;
        3'h3:    par_bound = hi ? 23'h0f_ffff : 23'h00_0000;
        3'h5:    par_bound = hi ? 23'h7f_ffff : 23'h40_0000;
        3'h6:    par_bound = hi ? 23'h7f_ffff : 23'h60_0000;
        3'h7:    par_bound = hi ? 23'h7f_ffff : 23'h70_0000;
        default: par_bound = 23'h00_0000;
      endcase
    end
  endfunction

  // sequence data word to register select code
  function [1:0] sw_code;
    input [15:0] data;
    begin
      if (data == `RCID_SW_REFRESH) begin
        sw_code = `RCID_SEL_REFRESH;
      end else if (data == `RCID_SW_IDENT) begin
        sw_code = `RCID_SEL_IDENT;
      end else begin
        sw_code = `RCID_SEL_NONE;
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  wire [43:0] pins_s;
  wire        s_ce_n;
  wire        s_we_n;
  wire        s_oe_n;
  wire        s_cre;
  wire        s_vce;
  wire [22:0] s_addr;
  wire [15:0] s_dq;

  rcid_sync #(
    .WIDTH (44)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({~ce_n, ~we_n, ~oe_n, register_select_pin, virtual_select_input, addr, dq_in}),
    .pin_sync (pins_s)
  );

  // strobes travel inverted so the zero reset of the stages reads as idle, not as a select
  assign {s_ce_n, s_we_n, s_oe_n, s_cre, s_vce, s_addr, s_dq} = pins_s ^ {3'b111, 41'h000_0000_0000};

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg  [15:0] refresh_control_reg;
  reg  [15:0] refresh_control_next;
  reg         dpd_reg;
  reg         init_reg;
  reg         lost_reg;
  reg         sel_prev_reg;
  reg         we_n_prev_reg;
  reg         wr_seen_reg;
  reg         addr_bad_reg;
  reg  [3:0]  sw_state_reg;
  reg  [3:0]  sw_state_next;
  reg  [1:0]  sw_sel_reg;
  reg  [15:0] rd_data;
  reg         rd_hit;
  wire [15:0] identification_word;
  wire        chip_sel;
  wire        we_rise;
  wire        we_fall;
  wire        desel_edge;
  wire        access_ok;
  wire        at_sw_addr;
  wire        cre_wr;
  wire        sw_wr;
  wire        exit_done;
  wire        init_done;

  // RULE10: fixed identification layout
  assign identification_word = {`RCID_ID_ROW_256, REVISION, `RCID_ID_DENSITY,
                                `RCID_ID_GENERATION, VENDOR};

  // RULE11 RULE12: die answers only in its half of the stacked space
  assign chip_sel   = !s_ce_n && (s_vce == UPPER);
  assign we_rise    = chip_sel && !we_n_prev_reg && s_we_n;
  assign we_fall    = chip_sel && we_n_prev_reg && !s_we_n;
  assign desel_edge = sel_prev_reg && !chip_sel;
  // RULE3: no access taken during power-down or initialization
  assign access_ok  = !dpd_reg && !init_reg;
  assign at_sw_addr = (s_addr == `RCID_SW_ADDR);

  // RULE13: write through the select pin
  assign cre_wr = access_ok && we_rise && s_cre && (s_addr[19:18] == `RCID_SEL_REFRESH);
  // RULE13: write as the final access of the software sequence
  assign sw_wr  = access_ok && we_rise && !s_cre && (sw_state_reg == SW_SEL) && at_sw_addr
                  && (sw_sel_reg == `RCID_SEL_REFRESH);

  // ---------------------------------------------------------------
  // power-down exit and initialization timers
  // ---------------------------------------------------------------
  // RULE5: chip select held low long enough ends power-down
  rcid_timer #(
    .COUNT (EXIT_CYC),
    .W     (12)
  ) u_exit_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (dpd_reg && chip_sel),
    .done    (exit_done)
  );

  // RULE3: initialization interval after refresh restarts
  rcid_timer #(
    .COUNT (INIT_CYC),
    .W     (12)
  ) u_init_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (init_reg),
    .done    (init_done)
  );

  // ---------------------------------------------------------------
  // refresh_control next value
  // ---------------------------------------------------------------
  // RULE8: writes to the identification register fall away
  always @* begin
    refresh_control_next = refresh_control_reg;
    if (dpd_reg && exit_done) begin
      // RULE5: hardware sets the deep-sleep bit on exit
      refresh_control_next[`RCID_DS_BIT] = 1'b1;
    end else if (cre_wr || sw_wr) begin
      // RULE7: page bit and the other fields are plain storage
      refresh_control_next = s_dq & `RCID_REFRESH_MASK;
    end
  end

  // ---------------------------------------------------------------
  // software access sequence: read, read, write select, access
  // ---------------------------------------------------------------
  always @* begin
    sw_state_next = sw_state_reg;
    if (desel_edge) begin
      if (s_cre || addr_bad_reg) begin
        sw_state_next = SW_IDLE;
      end else begin
        case (sw_state_reg)
          SW_IDLE: sw_state_next = wr_seen_reg ? SW_IDLE : SW_ONE;
          SW_ONE:  sw_state_next = wr_seen_reg ? SW_IDLE : SW_TWO;
          SW_TWO:  sw_state_next = wr_seen_reg ? SW_SEL : SW_IDLE;
          SW_SEL:  sw_state_next = SW_IDLE;
          default: sw_state_next = SW_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  always @* begin
    rd_hit  = 1'b0;
    rd_data = 16'h0000;
    if (access_ok && chip_sel && !s_oe_n && s_we_n) begin
      if (s_cre) begin
        // RULE13 RULE9: select pin with address bits 19:18
        if (s_addr[19:18] == `RCID_SEL_REFRESH) begin
          rd_hit  = 1'b1;
          rd_data = refresh_control_reg;
        end else if (s_addr[19:18] == `RCID_SEL_IDENT) begin
          rd_hit  = 1'b1;
          rd_data = identification_word;
        end
      end else if ((sw_state_reg == SW_SEL) && at_sw_addr) begin
        // RULE9: sequence data 0002h picks the identification word
        if (sw_sel_reg == `RCID_SEL_REFRESH) begin
          rd_hit  = 1'b1;
          rd_data = refresh_control_reg;
        end else if (sw_sel_reg == `RCID_SEL_IDENT) begin
          rd_hit  = 1'b1;
          rd_data = identification_word;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // access tracking
  // ---------------------------------------------------------------
  // per chip-select cycle: was it a write, did the address stray
  always @(posedge ref_clk) begin
    if (rst) begin
      sel_prev_reg  <= 1'b0;
      we_n_prev_reg <= 1'b1;
      wr_seen_reg   <= 1'b0;
      addr_bad_reg  <= 1'b0;
      sw_state_reg  <= SW_IDLE;
      sw_sel_reg    <= `RCID_SEL_NONE;
    end else begin
      sel_prev_reg  <= chip_sel;
      we_n_prev_reg <= s_we_n;
      sw_state_reg  <= sw_state_next;
      if (desel_edge) begin
        wr_seen_reg  <= 1'b0;
        addr_bad_reg <= 1'b0;
      end else begin
        if (we_fall) begin
          wr_seen_reg <= 1'b1;
        end
        if (chip_sel && !at_sw_addr) begin
          addr_bad_reg <= 1'b1;
        end
      end
      // data of the third access picks the target register
      if (we_rise && (sw_state_reg == SW_TWO)) begin
        sw_sel_reg <= sw_code(s_dq);
      end
    end
  end

  // ---------------------------------------------------------------
  // register and power state
  // ---------------------------------------------------------------
  // RULE6: only the writes and the exit touch refresh_control, never power-down itself
  always @(posedge ref_clk) begin
    if (rst) begin
      refresh_control_reg <= `RCID_REFRESH_RESET;
      dpd_reg             <= 1'b0;
      init_reg            <= 1'b0;
      lost_reg            <= 1'b0;
    end else begin
      refresh_control_reg <= refresh_control_next;
      if (!dpd_reg && desel_edge && !refresh_control_reg[`RCID_DS_BIT]) begin
        // RULE4: deselect with the deep-sleep bit clear enters power-down
        dpd_reg  <= 1'b1;
        // RULE2: array contents are no longer guaranteed
        lost_reg <= 1'b1;
      end else if (dpd_reg && exit_done) begin
        // RULE3: refresh restarts and initialization begins
        dpd_reg  <= 1'b0;
        init_reg <= 1'b1;
      end else if (init_done) begin
        init_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      dq_out            <= 16'h0000;
      dq_oe             <= 1'b0;
      refresh_run       <= 1'b0;
      refresh_lo_addr   <= 23'h00_0000;
      refresh_hi_addr   <= 23'h00_0000;
      page_mode_en      <= 1'b0;
      deep_sleep_active <= 1'b0;
      init_busy         <= 1'b0;
      contents_lost     <= 1'b0;
      die_selected      <= 1'b0;
    end else begin
      dq_out            <= rd_data;
      dq_oe             <= rd_hit;
      // RULE2: power-down halts refresh
      // RULE1: region from the partial refresh code
      refresh_run       <= !dpd_reg &&
                           (refresh_control_reg[`RCID_PAR_MSB:`RCID_PAR_LSB] != `RCID_PAR_NONE);
      refresh_lo_addr   <= par_bound(refresh_control_reg[`RCID_PAR_MSB:`RCID_PAR_LSB], 1'b0);
      refresh_hi_addr   <= par_bound(refresh_control_reg[`RCID_PAR_MSB:`RCID_PAR_LSB], 1'b1);
      // RULE7: page mode follows bit 7
      page_mode_en      <= refresh_control_reg[`RCID_PAGE_BIT];
      deep_sleep_active <= dpd_reg;
      init_busy         <= init_reg;
      contents_lost     <= lost_reg;
      die_selected      <= chip_sel;
    end
  end

endmodule

// *** bench/rcid_regs_props.sv ***
// concurrent checks on the ports of the refresh and identification register bank
`timescale 1ns/1ps
module rcid_regs_props #(
  parameter UPPER_DIE = 0
) (
  // clock and reset
  input wire        ref_clk,
  input wire        rst,
  // memory bus pins
  input wire        ce_n,
  input wire        we_n,
  input wire        oe_n,
  input wire        virtual_select_input,
  input wire        dq_oe,
  // refresh and power state
  input wire        refresh_run,
  input wire [22:0] refresh_lo_addr,
  input wire [22:0] refresh_hi_addr,
  input wire        page_mode_en,
  input wire        deep_sleep_active,
  input wire        init_busy,
  input wire        contents_lost,
  input wire        die_selected
);
  reg [11:0] init_cnt_reg;
  reg [11:0] low_cnt_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // run lengths of init and of qualified chip select low; the chip select count saturates so it never wraps
  always @(posedge ref_clk) begin
    if (rst) begin
      init_cnt_reg <= 12'h000;
      low_cnt_reg  <= 12'h000;
    end else begin
      init_cnt_reg <= init_busy ? init_cnt_reg + 12'h001 : 12'h000;
      if (ce_n || virtual_select_input != (UPPER_DIE != 0))
        low_cnt_reg <= 12'h000;
      else if (low_cnt_reg != 12'hfff)
        low_cnt_reg <= low_cnt_reg + 12'h001;
    end
  end

  sleep_refresh_a: assert property (
    deep_sleep_active |-> !refresh_run && !dq_oe)
    else $error("refresh or drive during power-down");
  lost_sticky_a: assert property (
    contents_lost |=> contents_lost)
    else $error("lost flag cleared without reset");
  sleep_entry_a: assert property (
    $rose(deep_sleep_active) |-> $past(ce_n, 2) ##[0:1] contents_lost)
    else $error("power-down entered without deselect");
  sleep_exit_a: assert property (
    $fell(deep_sleep_active) |-> low_cnt_reg >= 12'd200 && low_cnt_reg <= 12'd208)
    else $error("power-down left after wrong low time");
  init_start_a: assert property (
    $fell(deep_sleep_active) |-> ##[0:1] init_busy)
    else $error("no initialization after power-down exit");
  init_len_a: assert property (
    $fell(init_busy) |-> init_cnt_reg >= 12'd2999 && init_cnt_reg <= 12'd3001)
    else $error("initialization length wrong");
  reset_default_a: assert property (
    $fell(rst) |-> ##1 refresh_run && !page_mode_en && refresh_lo_addr == 23'h0
      && refresh_hi_addr == 23'h7f_ffff)
    else $error("power-up refresh defaults wrong");
  par_region_a: assert property (
    refresh_run |-> (refresh_lo_addr == 23'h0 && refresh_hi_addr inside
      {23'h7f_ffff, 23'h3f_ffff, 23'h1f_ffff, 23'h0f_ffff}) || (refresh_hi_addr ==
      23'h7f_ffff && refresh_lo_addr inside {23'h40_0000, 23'h60_0000, 23'h70_0000}))
    else $error("refresh region not a legal partition");
  die_match_a: assert property (
    $rose(die_selected) |-> $past(virtual_select_input, 2) == (UPPER_DIE != 0)
      && !$past(ce_n, 2))
    else $error("die selected on wrong virtual select");
  read_drive_a: assert property (
    $rose(dq_oe) |-> !$past(oe_n, 2) && !$past(ce_n, 2) && $past(we_n, 2))
    else $error("data driven without a read");
endmodule

bind rcid_regs rcid_regs_props #(.UPPER_DIE(UPPER_DIE)) i_props (
  .ref_clk(ref_clk), .rst(rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
  .virtual_select_input(virtual_select_input), .dq_oe(dq_oe), .refresh_run(refresh_run),
  .refresh_lo_addr(refresh_lo_addr), .refresh_hi_addr(refresh_hi_addr),
  .page_mode_en(page_mode_en), .deep_sleep_active(deep_sleep_active),
  .init_busy(init_busy), .contents_lost(contents_lost), .die_selected(die_selected));

// *** bench/rcid_host.sv ***
// host controller model driving the memory bus pins
`timescale 1ns/1ps
module rcid_host (
  // clock
  input  wire        ref_clk,
  // pins toward the memory
  output reg         ce_n,
  output reg         we_n,
  output reg         oe_n,
  output reg         register_select_pin,
  output reg         virtual_select_input,
  output reg  [22:0] addr,
  output reg  [15:0] dq_in,
  // read data back
  input  wire [15:0] dq_out,
  input  wire        dq_oe
);
  // idle bus, deselected
  initial begin
    ce_n                 = 1'b1;
    we_n                 = 1'b1;
    oe_n                 = 1'b1;
    register_select_pin  = 1'b0;
    virtual_select_input = 1'b0;
    addr                 = 23'h00_0000;
    dq_in                = 16'h0000;
  end

  task wait_n(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one chip-select cycle; every level held at least 4 cycles so the synchronisers take it
  task acc(input rs, input [22:0] a, input wr, input [15:0] d, output [15:0] q, output o);
    register_select_pin = rs;
    addr                = a;
    ce_n                = 1'b0;
    wait_n(4);
    if (wr) begin
      dq_in = d;
      we_n  = 1'b0;
      wait_n(4);
      we_n = 1'b1;
    end else begin
      oe_n = 1'b0;
      wait_n(8);
    end
    q = dq_out;
    o = dq_oe;
    wait_n(4);
    // deselect after the access; released data lines show inverted value
    ce_n  = 1'b1;
    oe_n  = 1'b1;
    dq_in = ~dq_in;
    register_select_pin = 1'b0;
    wait_n(4);
  endtask

  // two reads then a write carrying the selector
  task seq(input [15:0] sel);
    reg [15:0] q;
    reg        o;
    acc(1'b0, 23'h7f_ffff, 1'b0, 16'h0000, q, o);
    acc(1'b0, 23'h7f_ffff, 1'b0, 16'h0000, q, o);
    acc(1'b0, 23'h7f_ffff, 1'b1, sel, q, o);
  endtask
endmodule

// *** bench/rcid_regs_test.sv ***
// self-checking testbench for the refresh and identification register bank
`timescale 1ns/1ps
module rcid_regs_test;
  localparam [3:0]  REV    = 4'ha;     // arbitrary value
  localparam [4:0]  VEND   = 5'h0c;    // arbitrary value
  localparam [15:0] ID_EXP = {1'b1, REV, 3'h3, 3'h2, VEND};
  reg         ref_clk;
  reg         rst;
  wire        ce_n, we_n, oe_n, register_select_pin, virtual_select_input;
  wire [22:0] addr;
  wire [15:0] dq_in;
  wire [15:0] dq_out;
  wire        dq_oe, refresh_run, page_mode_en, deep_sleep_active;
  wire        init_busy, contents_lost, die_selected;
  wire [22:0] refresh_lo_addr, refresh_hi_addr, hi_addr_up;
  integer     err_total, check_count, i, n, m;
  reg  [15:0] q;
  reg         oe;
  reg  [22:0] sz;

  rcid_regs #(.UPPER_DIE(0), .REVISION(REV), .VENDOR(VEND)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .register_select_pin(register_select_pin), .virtual_select_input(virtual_select_input),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .refresh_run(refresh_run),
    .refresh_lo_addr(refresh_lo_addr), .refresh_hi_addr(refresh_hi_addr),
    .page_mode_en(page_mode_en), .deep_sleep_active(deep_sleep_active),
    .init_busy(init_busy), .contents_lost(contents_lost), .die_selected(die_selected));

  // second die in the upper half of the stacked space, on the same pins
  rcid_regs #(.UPPER_DIE(1), .REVISION(REV), .VENDOR(VEND)) i_dut_hi (
    .ref_clk(ref_clk), .rst(rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .register_select_pin(register_select_pin), .virtual_select_input(virtual_select_input),
    .addr(addr), .dq_in(dq_in), .dq_out(), .dq_oe(), .refresh_run(),
    .refresh_lo_addr(), .refresh_hi_addr(hi_addr_up), .page_mode_en(),
    .deep_sleep_active(), .init_busy(), .contents_lost(), .die_selected());

  rcid_host i_host (
    .ref_clk(ref_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .register_select_pin(register_select_pin), .virtual_select_input(virtual_select_input),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  task chk(input string what, input [22:0] seen, input [22:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_of_test;
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // register access through the select pin, address bits 19:18 pick the register
  task pin_acc(input [1:0] s, input wr, input [15:0] d);
    i_host.acc(1'b1, {3'b000, s, 18'h0_0000}, wr, d, q, oe);
  endtask

  initial begin
    ref_clk     = 1'b0;
    rst         = 1'b1;
    err_total   = 0;
    check_count = 0;
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("page_mode_en", page_mode_en, 23'h0);
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("refresh_control", q, 23'h0010);
    // every partial refresh code, bottom sizes then none then top sizes
    for (i = 0; i < 8; i = i + 1) begin
      pin_acc(2'b00, 1'b1, 16'h0010 | i[15:0]);
      sz = 23'h7f_ffff >> i[1:0];
      chk("refresh_run", refresh_run, (i != 4));
      chk("refresh_lo", refresh_lo_addr, (i > 4) ? 23'h7f_ffff - sz : 23'h0);
      chk("refresh_hi", refresh_hi_addr, (i == 4) ? 23'h0 : (i > 4) ? 23'h7f_ffff : sz);
    end
    // all ones: reserved bits read zero, page mode on
    pin_acc(2'b00, 1'b1, 16'hffff);
    chk("page_mode_en", page_mode_en, 23'h1);
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("refresh_control", q, 23'h0097);
    // identification word read, write attempt, read again
    pin_acc(2'b01, 1'b0, 16'h0000);
    chk("ident", q, ID_EXP);
    pin_acc(2'b01, 1'b1, 16'h0000);
    pin_acc(2'b01, 1'b0, 16'h0000);
    chk("ident_after_write", q, ID_EXP);
    pin_acc(2'b10, 1'b0, 16'h0000);
    chk("reserved_drive", oe, 23'h0);
    // other die's half of the stacked space
    i_host.virtual_select_input = 1'b1;
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("other_die_drive", oe, 23'h0);
    // a write in the upper half lands only in the upper die
    pin_acc(2'b00, 1'b1, 16'h0013);
    chk("lower_region", refresh_hi_addr, 23'h7f_ffff);
    chk("upper_region", hi_addr_up, 23'h0f_ffff);
    i_host.virtual_select_input = 1'b0;
    // software sequence to both registers
    i_host.seq(16'h0002);
    i_host.acc(1'b0, 23'h7f_ffff, 1'b0, 16'h0000, q, oe);
    chk("seq_ident", q, ID_EXP);
    i_host.seq(16'h0000);
    i_host.acc(1'b0, 23'h7f_ffff, 1'b1, 16'h0013, q, oe);
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("seq_refresh", q, 23'h0013);
    // clear the deep-sleep bit through the sequence; the closing deselect enters
    i_host.seq(16'h0000);
    i_host.acc(1'b0, 23'h7f_ffff, 1'b1, 16'h0083, q, oe);
    // the deselect needs the synchroniser delay plus two register stages to show
    i_host.wait_n(4);
    chk("deep_sleep", deep_sleep_active, 23'h1);
    chk("refresh_run", refresh_run, 23'h0);
    chk("contents_lost", contents_lost, 23'h1);
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("sleep_drive", oe, 23'h0);
    // hold chip select low until the exit, then time the initialization
    i_host.ce_n = 1'b0;
    n = 0;
    while (deep_sleep_active && n < 300) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    m = 0;
    while (init_busy && m < 3200) begin
      @(negedge ref_clk);
      m = m + 1;
    end
    i_host.ce_n = 1'b1;
    i_host.wait_n(4);
    chk("exit_time", (n >= 200 && n <= 208), 23'h1);
    chk("init_time", (m >= 2997 && m <= 3003), 23'h1);
    if (n >= 300 || m >= 3200) begin
      err_total = err_total + 1;
      end_of_test;
    end
    pin_acc(2'b00, 1'b0, 16'h0000);
    chk("refresh_after_exit", q, 23'h0093);
    chk("page_after_exit", page_mode_en, 23'h1);
    end_of_test;
  end
endmodule
